// [src/phy_control_register.sv]
// Operation
// RL1 - Control register at management address 0, 16 bits, RW, resets to 0x3100
// RL2 - Reset defaults give normal operation without software setup
// RL3 - Duplex bit 8 set selects full duplex
// RL4 - Duplex bit 8 clear selects half duplex
// RL5 - Duplex set by software write or by auto-negotiation result
// RL6 - Collision-test bit 7 set enables collision test mode
// RL7 - Collision-test bit becomes set once a transmission starts
// RL8 - Collision-test bit cleared by device when transmission halts
// RL9 - Station writes zeros into reserved bits 6:0
// RL10 - Register reached by management read and write by register number
// RL11 - Register reset bit restores defaults, reinitialises, then self-clears
// RL12 - Restart bit restarts negotiation, self-clears once restart began
`include "phy_control_defines.svh"
`default_nettype none
module phy_control_register (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Management access
   input wire phy_control_pkg::reg_addr_t mgmt_addr,
   input wire logic mgmt_wr,
   input wire logic mgmt_rd,
   input wire phy_control_pkg::reg16_t mgmt_wdata,
   output phy_control_pkg::reg16_t mgmt_rdata,
   output logic mgmt_rvalid,
   // Auto-negotiation
   input wire logic aneg_resolved,
   input wire logic aneg_full_duplex,
   input wire logic aneg_restart_begun,
   output logic aneg_restart_req,
   // Transmit activity
   input wire logic tx_started,
   input wire logic tx_halted,
   // Operating controls
   output logic full_duplex,
   output logic collision_test_enable,
   output logic autoneg_enable,
   output logic speed_select,
   output logic loop_back,
   output logic low_power_down,
   output logic isolate,
   output logic soft_reset
);
   import phy_control_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   reg16_t ctrl_r;
   reg16_t ctrl_nxt;
   reg16_t rdata_r;
   reg16_t rdata_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   logic soft_reset_r;
   logic soft_reset_nxt;
   logic hit;
   logic wr_hit;
   logic col_bit;
   logic col_set;

   assign hit = (mgmt_addr == `PHYC_ADDR); // RL10
   assign wr_hit = mgmt_wr && hit;

   // Collision-test bit: software write or transmit start sets, halt clears
   assign col_set = tx_started ||
      (wr_hit && mgmt_wdata[`PHYC_BIT_COL_TEST]); // RL6 RL7
   // Soft reset clears synchronously; a logic-driven async reset could glitch
   pulse_stretch_clear u_col (
      .clk(clk),
      .rst(rst),
      .set_req(col_set && !soft_reset_r),
      .clear_req(tx_halted || soft_reset_r ||
         (wr_hit && !mgmt_wdata[`PHYC_BIT_COL_TEST])), // RL8 RL11
      .flag(col_bit)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      ctrl_nxt = ctrl_r;
      soft_reset_nxt = 1'b0;
      if (soft_reset_r) begin
         ctrl_nxt = `PHYC_RESET_VALUE; // RL11
      end else begin
         if (wr_hit) begin
            // Reserved bits are dropped so a careless write cannot disturb them
            ctrl_nxt = mgmt_wdata & ~`PHYC_RSVD_MASK; // RL1 RL9
            soft_reset_nxt = mgmt_wdata[`PHYC_BIT_REG_RESET]; // RL11
         end
         if (aneg_resolved) begin
            ctrl_nxt[`PHYC_BIT_DUPLEX] = aneg_full_duplex; // RL5
         end
         // Restart request holds until negotiation reports it has begun
         if (aneg_restart_begun && !(wr_hit && mgmt_wdata[`PHYC_BIT_ANEG_RESTART])) begin
            ctrl_nxt[`PHYC_BIT_ANEG_RESTART] = 1'b0; // RL12
         end
         ctrl_nxt[`PHYC_BIT_REG_RESET] = 1'b0;
      end
      ctrl_nxt[`PHYC_BIT_COL_TEST] = 1'b0;
   end

   always_comb begin
      rdata_nxt = rdata_r;
      rvalid_nxt = 1'b0;
      if (mgmt_rd) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = 16'h0000;
         if (hit) begin
            rdata_nxt = ctrl_r | ({15'h0000, col_bit} << `PHYC_BIT_COL_TEST);
            rdata_nxt[`PHYC_BIT_REG_RESET] = soft_reset_r;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= `PHYC_RESET_VALUE; // RL1 RL2
         rdata_r <= 16'h0000;
         rvalid_r <= 1'b0;
         soft_reset_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         soft_reset_r <= soft_reset_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign mgmt_rdata = rdata_r;
   assign mgmt_rvalid = rvalid_r;
   assign full_duplex = ctrl_r[`PHYC_BIT_DUPLEX]; // RL3 RL4
   assign collision_test_enable = col_bit; // RL6
   assign autoneg_enable = ctrl_r[`PHYC_BIT_ANEG_EN];
   assign speed_select = ctrl_r[`PHYC_BIT_SPEED];
   assign loop_back = ctrl_r[`PHYC_BIT_LOOP_BACK];
   assign low_power_down = ctrl_r[`PHYC_BIT_POWER_DOWN];
   assign isolate = ctrl_r[`PHYC_BIT_ISOLATE];
   assign aneg_restart_req = ctrl_r[`PHYC_BIT_ANEG_RESTART]; // RL12
   assign soft_reset = soft_reset_r; // RL11

   ////////////////////////////////////////////////////////////////////////
   a_reset_value: assert property (@(posedge clk) disable iff (rst) // RL11
      $fell(soft_reset_r) |-> ctrl_r == `PHYC_RESET_VALUE)
      else $error("control not at defaults after register reset");
   a_duplex_out: assert property (@(posedge clk) disable iff (rst) // RL3 RL4
      (wr_hit && !aneg_resolved && !soft_reset_r) |=>
      full_duplex == $past(mgmt_wdata[`PHYC_BIT_DUPLEX]))
      else $error("written duplex not applied");
   a_duplex_aneg: assert property (@(posedge clk) disable iff (rst) // RL5
      (aneg_resolved && !soft_reset_r) |=> full_duplex == $past(aneg_full_duplex))
      else $error("negotiated duplex not taken");
   a_col_start: assert property (@(posedge clk) disable iff (rst) // RL7
      (tx_started && !soft_reset_r) |=> collision_test_enable)
      else $error("collision test not set on transmit start");
   a_col_halt: assert property (@(posedge clk) disable iff (rst) // RL8
      (tx_halted && !col_set && !soft_reset_r) |=> !collision_test_enable)
      else $error("collision test not cleared on halt");
   a_rsvd_zero: assert property (@(posedge clk) disable iff (rst) // RL9
      (ctrl_r & `PHYC_RSVD_MASK) == 16'h0000)
      else $error("reserved bits not zero");
   a_selfclear_rst: assert property (@(posedge clk) disable iff (rst) // RL11
      soft_reset_r |=> !soft_reset_r)
      else $error("register reset did not self clear");
   a_restart_clear: assert property (@(posedge clk) disable iff (rst) // RL12
      (aneg_restart_begun && !wr_hit) |=> !aneg_restart_req)
      else $error("restart bit not cleared");
   a_read_answer: assert property (@(posedge clk) disable iff (rst) // RL10
      (mgmt_rd && hit && !soft_reset_r) |=>
      mgmt_rvalid && mgmt_rdata[14:8] == $past(ctrl_r[14:8]))
      else $error("read answer wrong");

   ////////////////////////////////////////////////////////////////////////
   // Write side
   a_write_lands: assert property (@(posedge clk) disable iff (rst) // RL1
      (wr_hit && !aneg_resolved && !soft_reset_r) |=>
      ctrl_r == ($past(mgmt_wdata) & 16'h7f00))
      else $error("written control value not stored");
   a_ctl_outputs: assert property (@(posedge clk) disable iff (rst) // RL1
      (wr_hit && !soft_reset_r) |=>
      {loop_back, speed_select, autoneg_enable, low_power_down, isolate} ==
      $past(mgmt_wdata[14:10]))
      else $error("control outputs do not follow write");
   a_unmapped_wr: assert property (@(posedge clk) disable iff (rst) // RL10
      (mgmt_wr && !hit && !aneg_resolved && !aneg_restart_begun && !soft_reset_r) |=>
      ctrl_r == $past(ctrl_r))
      else $error("unmapped write changed control");
   a_soft_start: assert property (@(posedge clk) disable iff (rst) // RL11
      (wr_hit && mgmt_wdata[`PHYC_BIT_REG_RESET] && !soft_reset_r) |=> soft_reset)
      else $error("register reset not started");
   a_soft_outputs: assert property (@(posedge clk) disable iff (rst) // RL2 RL11
      $fell(soft_reset_r) |-> full_duplex && autoneg_enable && speed_select &&
      !loop_back && !low_power_down && !isolate && !aneg_restart_req && !collision_test_enable)
      else $error("outputs not at defaults after register reset");
   a_soft_col: assert property (@(posedge clk) disable iff (rst) // RL11
      soft_reset_r |=> !collision_test_enable)
      else $error("register reset left collision test set");
   a_restart_set: assert property (@(posedge clk) disable iff (rst) // RL12
      (wr_hit && mgmt_wdata[`PHYC_BIT_ANEG_RESTART] && !soft_reset_r) |=> aneg_restart_req)
      else $error("restart request not raised");
   a_restart_hold: assert property (@(posedge clk) disable iff (rst) // RL12
      (!wr_hit && !aneg_restart_begun && !soft_reset_r) |=>
      aneg_restart_req == $past(aneg_restart_req))
      else $error("restart request changed on its own");
   a_col_write: assert property (@(posedge clk) disable iff (rst) // RL6
      (wr_hit && mgmt_wdata[`PHYC_BIT_COL_TEST] && !soft_reset_r) |=> collision_test_enable)
      else $error("collision test write not applied");
   a_col_hold: assert property (@(posedge clk) disable iff (rst) // RL7 RL8
      (!col_set && !tx_halted && !wr_hit && !soft_reset_r) |=>
      collision_test_enable == $past(collision_test_enable))
      else $error("collision test changed on its own");
   // Read side
   a_rvalid_pulse: assert property (@(posedge clk) disable iff (rst) // RL10
      !mgmt_rd |=> !mgmt_rvalid)
      else $error("read answer without a read");
   a_read_hold: assert property (@(posedge clk) disable iff (rst) // RL10
      !mgmt_rd |=> $stable(mgmt_rdata))
      else $error("read data moved between reads");
   a_unmapped_rd: assert property (@(posedge clk) disable iff (rst) // RL10
      (mgmt_rd && !hit) |=> mgmt_rvalid && mgmt_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_read_col: assert property (@(posedge clk) disable iff (rst) // RL6
      (mgmt_rd && hit) |=> mgmt_rdata[`PHYC_BIT_COL_TEST] == $past(collision_test_enable))
      else $error("collision test bit misread");
   a_read_soft: assert property (@(posedge clk) disable iff (rst) // RL11
      (mgmt_rd && hit) |=> mgmt_rdata[`PHYC_BIT_REG_RESET] == $past(soft_reset_r))
      else $error("register reset bit misread");
   a_rsvd_read: assert property (@(posedge clk) disable iff (rst) // RL9
      mgmt_rvalid |-> (mgmt_rdata & `PHYC_RSVD_MASK) == 16'h0000)
      else $error("reserved bits read nonzero");
endmodule // phy_control_register
`default_nettype wire

// [shared/phy_control_defines.svh]
`ifndef PHY_CONTROL_DEFINES_SVH
`define PHY_CONTROL_DEFINES_SVH
`define PHYC_ADDR 5'h00
`define PHYC_RESET_VALUE 16'h3100
`define PHYC_BIT_REG_RESET 15
`define PHYC_BIT_LOOP_BACK 14
`define PHYC_BIT_SPEED 13
`define PHYC_BIT_ANEG_EN 12
`define PHYC_BIT_POWER_DOWN 11
`define PHYC_BIT_ISOLATE 10
`define PHYC_BIT_ANEG_RESTART 9
`define PHYC_BIT_DUPLEX 8
`define PHYC_BIT_COL_TEST 7
`define PHYC_RSVD_MASK 16'h007f
`endif

// [shared/phy_control_pkg.sv]
`default_nettype none
package phy_control_pkg;
   typedef logic [15:0] reg16_t;
   typedef logic [4:0] reg_addr_t;
endpackage
`default_nettype wire

// [src/pulse_stretch_clear.sv]
`default_nettype none
// Self-clearing bit: set by a pulse, cleared by a done pulse; set wins
module pulse_stretch_clear (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic set_req,
   input wire logic clear_req,
   output logic flag
);
   logic bit_r;
   logic bit_nxt;
   always_comb begin
      bit_nxt = bit_r;
      if (clear_req) begin
         bit_nxt = 1'b0;
      end
      if (set_req) begin
         bit_nxt = 1'b1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bit_r <= 1'b0;
      end else begin
         bit_r <= bit_nxt;
      end
   end
   assign flag = bit_r;
endmodule // pulse_stretch_clear
`default_nettype wire

// [verif/mgmt_station.sv]
`default_nettype none
// Management station: fixed one-cycle strobes, data inverted once released
module mgmt_station (
   // Clock
   input wire logic clk,
   // Management access
   output phy_control_pkg::reg_addr_t mgmt_addr,
   output logic mgmt_wr,
   output logic mgmt_rd,
   output phy_control_pkg::reg16_t mgmt_wdata,
   input wire phy_control_pkg::reg16_t mgmt_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   import phy_control_pkg::*;
   initial begin
      mgmt_addr = 5'h00;
      mgmt_wr = 1'b0;
      mgmt_rd = 1'b0;
      mgmt_wdata = 16'h0000;
   end
   task automatic wr(input reg_addr_t a, input reg16_t d);
      @(negedge clk);
      mgmt_addr = a;
      mgmt_wdata = d & ~16'h007f;
      mgmt_wr = 1'b1;
      @(negedge clk);
      mgmt_wr = 1'b0;
      mgmt_wdata = ~mgmt_wdata;
   endtask
   task automatic rd(input reg_addr_t a, output reg16_t d);
      @(negedge clk);
      mgmt_addr = a;
      mgmt_rd = 1'b1;
      @(negedge clk);
      mgmt_rd = 1'b0;
      d = mgmt_rdata;
   endtask
endmodule // mgmt_station
`default_nettype wire

// [verif/tb_top.sv]
`default_nettype none
`define CHK(n,e,s) begin checks++; if ((s)!==(e)) begin error_cnt++; \
   $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import phy_control_pkg::*;
   logic clk = 1'b0, rst = 1'b1, ares = 1'b0, afd = 1'b0, abeg = 1'b0, txs = 1'b0, txh = 1'b0;
   logic wr, rd, rv, fd, cte, ane, spd, lb, pd, iso, srst, rreq;
   reg_addr_t addr;
   reg16_t wd, rdat, v;
   int error_cnt = 0, checks = 0;
   initial forever #25 clk = ~clk;
   phy_control_register i_phy_control_register (.clk(clk), .rst(rst), .mgmt_addr(addr),
      .mgmt_wr(wr), .mgmt_rd(rd), .mgmt_wdata(wd), .mgmt_rdata(rdat), .mgmt_rvalid(rv),
      .aneg_resolved(ares), .aneg_full_duplex(afd), .aneg_restart_begun(abeg),
      .aneg_restart_req(rreq), .tx_started(txs), .tx_halted(txh), .full_duplex(fd),
      .collision_test_enable(cte), .autoneg_enable(ane), .speed_select(spd),
      .loop_back(lb), .low_power_down(pd), .isolate(iso), .soft_reset(srst));
   mgmt_station i_mgmt_station (.clk(clk), .mgmt_addr(addr), .mgmt_wr(wr), .mgmt_rd(rd),
      .mgmt_wdata(wd), .mgmt_rdata(rdat));
   task automatic print_verdict;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   // Rvalid is a one-cycle pulse, so it is sampled in the cycle after the strobe
   task automatic rd_chk(input reg_addr_t a, input reg16_t e);
      i_mgmt_station.rd(a, v);
      `CHK("rvalid", 1'b1, rv)
      `CHK("rdata", e, v)
   endtask
   task automatic t_reset;
      rd_chk(5'h00, 16'h3100);
      `CHK("defaults", 3'h7, {fd, ane, spd})
      `CHK("idle ctl", 6'h00, {lb, pd, iso, cte, rreq, srst})
      $display("test reset done");
   endtask
   task automatic t_duplex;
      i_mgmt_station.wr(5'h00, 16'h3000);
      `CHK("half", 1'b0, fd)
      afd = 1'b1;
      pulse(ares);
      `CHK("aneg full", 1'b1, fd)
      afd = 1'b0;
      i_mgmt_station.wr(5'h00, 16'h3100);
      `CHK("full", 1'b1, fd)
      pulse(ares);
      `CHK("aneg duplex", 1'b0, fd)
      rd_chk(5'h00, 16'h3000);
      $display("test duplex done");
   endtask
   task automatic t_collision_test_enable;
      pulse(txs);
      `CHK("collision_test_enable set", 1'b1, cte)
      rd_chk(5'h00, 16'h3080);
      pulse(txh);
      `CHK("collision_test_enable clr", 1'b0, cte)
      i_mgmt_station.wr(5'h00, 16'h30ff);
      `CHK("collision_test_enable wr", 1'b1, cte)
      rd_chk(5'h00, 16'h3080);
      $display("test collision done");
   endtask
   task automatic t_map;
      i_mgmt_station.wr(5'h01, 16'h0000);
      rd_chk(5'h01, 16'h0000);
      rd_chk(5'h00, 16'h3080);
      i_mgmt_station.wr(5'h00, 16'h3280);
      `CHK("restart req", 1'b1, rreq)
      pulse(abeg);
      `CHK("restart clr", 1'b0, rreq)
      $display("test map done");
   endtask
   task automatic t_soft;
      i_mgmt_station.wr(5'h00, 16'h4c00);
      `CHK("ctl set", 5'h13, {lb, spd, ane, pd, iso})
      i_mgmt_station.wr(5'h00, 16'h8000);
      `CHK("soft pulse", 1'b1, srst)
      @(negedge clk);
      `CHK("soft end", 1'b0, srst)
      `CHK("ctl dflt", 6'h07, {lb, pd, iso, fd, ane, spd})
      rd_chk(5'h00, 16'h3100);
      $display("test soft reset done");
   endtask
   // Whole run is under 100 cycles; the limit leaves ample margin
   initial begin
      #20000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_duplex();
      t_collision_test_enable();
      t_map();
      t_soft();
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
